// ==== hw/obsl_pkg.sv ====
// option bit shadow loader shared constants
package obsl_pkg;
    localparam logic [11:0] OBSL_OPT1_ADDR      = 12'hd0f;
    localparam int          OBSL_MAIN_PROT_BIT  = 0;
    localparam int          OBSL_LOW_PROT_BIT   = 1;
    localparam int          OBSL_NODIV_BIT      = 2;
    localparam int          OBSL_RECOVER_LD_BIT = 5;
    localparam logic [7:0]  OBSL_OPT1_RST       = 8'h04;
    localparam logic [7:0]  OBSL_OPT1_WMASK     = 8'h04;
    localparam logic [7:0]  OBSL_OPT1_RMASK     = 8'h07;
    localparam int          OBSL_NUM_BYTES      = 2;
    localparam logic [2:0]  OBSL_LOAD_CYCLES    = 3'h4;
    typedef enum logic [1:0] {OBSL_IDLE, OBSL_WAIT, OBSL_FETCH, OBSL_DONE} obsl_state_e;
endpackage

// ==== hw/obsl_shadow_mem.sv ====
// shadow option byte storage with registered read port
module obsl_shadow_mem #(
    parameter int NUM_BYTES = 2
) (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         resetn,
    // write side
    input  wire logic                         wr_en,
    input  wire logic [$clog2(NUM_BYTES)-1:0] wr_idx,
    input  wire logic [7:0]                   wr_data,
    input  wire logic [7:0]                   wr_mask,
    // read side
    input  wire logic [$clog2(NUM_BYTES)-1:0] rd_idx,
    output logic      [7:0]                   rd_data,
    // all bytes, flattened
    output logic      [8*NUM_BYTES-1:0]       all_q
);
    import obsl_pkg::*;
    localparam int IW = $clog2(NUM_BYTES);
    logic [7:0] mem_q [NUM_BYTES];
    logic [7:0] mem_d [NUM_BYTES];
    logic [7:0] rd_q;
    logic [7:0] rd_d;

    genvar g;
    generate
        for (g = 0; g < NUM_BYTES; g++) begin : g_byte
            always_comb begin
                mem_d[g] = mem_q[g];
                if (wr_en && (wr_idx == IW'(g))) begin
                    mem_d[g] = (mem_q[g] & ~wr_mask) | (wr_data & wr_mask);
                end
            end
            // predefined value at start of reset; byte 0 carries no-divide default
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    mem_q[g] <= (g == 0) ? OBSL_OPT1_RST : 8'h00;
                end else begin
                    mem_q[g] <= mem_d[g];
                end
            end
            assign all_q[8*g +: 8] = mem_q[g];
        end
    endgenerate

    always_comb begin
        rd_d = mem_q[rd_idx];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_q <= 8'h00;
        end else begin
            rd_q <= rd_d;
        end
    end
    assign rd_data = rd_q;
endmodule // obsl_shadow_mem

// ==== hw/obsl_loader.sv ====
// option bit shadow loader: reset-time load, protect gating, cpu view
//
// Behaviour
// - each option bit has a shadow bit; shadows drive feature enables
// - information block option data copied into shadows as reset releases; the loader copies it only after the reset interval ends
// - load on power-on reset, or recovery reset when control bit 5 set
// - shadows forced to predefined values while resetn is low; a recovery reset alone leaves them
// - option programming takes effect only after a subsequent reset
// - protect shadow one: both interfaces access main memory and page 3
// - protect shadow zero: main memory and page 3 writes blocked until mass erase
// - completed mass erase sets shadow protect bit unless it coincides with a load fetch cycle, flash bit untouched
// - after mass erase override both interfaces get full access
// - reserved shadow bits read zero, writes ignored
// - byte 1 shadow at d0f; no-divide bit 2 resets one, rw; bits 1:0 ro
module obsl_loader #(
    parameter int NUM_BYTES = obsl_pkg::OBSL_NUM_BYTES
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   resetn,
    // reset sequencing: high during the reset interval
    input  wire logic                   por_active,
    input  wire logic                   recovery_active,
    input  wire logic [7:0]             stop_recovery_control,
    // information block read port
    output logic                        info_rd,
    output logic [$clog2(NUM_BYTES)-1:0] info_idx,
    input  wire logic [7:0]             info_data,
    // mass erase completion pulse
    input  wire logic                   mass_erase_done,
    // cpu register access
    input  wire logic [11:0]            cpu_addr,
    input  wire logic                   cpu_wr,
    input  wire logic [7:0]             cpu_wdata,
    output logic      [7:0]             cpu_rdata,
    // feature enables and access grants
    output logic [8*NUM_BYTES-1:0]      option_shadow,
    output logic                        main_memory_access_ok,
    output logic                        clock_no_divide,
    output logic                        lower_half_protect,
    output logic                        load_done
);
    import obsl_pkg::*;
    localparam int IW = $clog2(NUM_BYTES);

    obsl_state_e    state_q, state_d;
    logic [2:0]     cnt_q, cnt_d;
    logic [IW-1:0]  idx_q, idx_d;
    logic           rd_q, rd_d;
    logic           done_q, done_d;
    logic           qual_q, qual_d;
    logic           acc_q, acc_d;
    logic [7:0]     rdata_q, rdata_d;
    logic [7:0]     cpu_sel_q, cpu_sel_d;
    logic           mem_wr;
    logic [IW-1:0]  mem_widx;
    logic [7:0]     mem_wdata, mem_wmask;
    logic [7:0]     mem_rd;
    logic [8*NUM_BYTES-1:0] all_q;
    logic           in_reset;
    logic           cpu_hit;

    assign in_reset = por_active | recovery_active;
    assign cpu_hit  = (cpu_addr == OBSL_OPT1_ADDR);

    // sequencer
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        idx_d   = idx_q;
        rd_d    = 1'b0;
        done_d  = done_q;
        qual_d  = qual_q | por_active
                | (recovery_active & stop_recovery_control[OBSL_RECOVER_LD_BIT]);
        case (state_q)
            OBSL_IDLE: begin
                if (in_reset && qual_d) begin
                    state_d = OBSL_WAIT;
                    cnt_d   = OBSL_LOAD_CYCLES;
                    done_d  = 1'b0;
                end
            end
            OBSL_WAIT: begin
                // fetch only once reset is releasing
                if (!in_reset) begin
                    state_d = OBSL_FETCH;
                    idx_d   = '0;
                    rd_d    = 1'b1;
                end
            end
            OBSL_FETCH: begin
                rd_d = 1'b1;
                if (idx_q == IW'(NUM_BYTES - 1)) begin
                    state_d = OBSL_DONE;
                    rd_d    = 1'b0;
                end else begin
                    idx_d = idx_q + 1'b1;
                end
            end
            OBSL_DONE: begin
                if (cnt_q != 3'h0) begin
                    cnt_d = cnt_q - 3'h1;
                end else begin
                    state_d = OBSL_IDLE;
                    done_d  = 1'b1;
                    // a cause arriving as the load ends still arms the next load
                    qual_d  = por_active
                            | (recovery_active & stop_recovery_control[OBSL_RECOVER_LD_BIT]);
                end
            end
            default: state_d = OBSL_IDLE;
        endcase
    end

    // shadow writes: load, mass erase override, cpu; never flash programming
    always_comb begin
        mem_wr    = 1'b0;
        mem_widx  = idx_q;
        mem_wdata = info_data;
        mem_wmask = 8'hff;
        // info data is sampled in the same cycle as the info_rd request
        if (rd_q) begin
            mem_wr = 1'b1;
        end else if (mass_erase_done) begin
            mem_wr    = 1'b1;
            mem_widx  = '0;
            mem_wdata = 8'hff;
            mem_wmask = 8'h01 << OBSL_MAIN_PROT_BIT;
        end else if (cpu_wr && cpu_hit && done_q) begin
            mem_wr    = 1'b1;
            mem_widx  = '0;
            mem_wdata = cpu_wdata;
            mem_wmask = OBSL_OPT1_WMASK;
        end
    end

    obsl_shadow_mem #(.NUM_BYTES(NUM_BYTES)) u_mem (
        .clk     (clk),
        .resetn  (resetn),
        .wr_en   (mem_wr),
        .wr_idx  (mem_widx),
        .wr_data (mem_wdata),
        .wr_mask (mem_wmask),
        .rd_idx  ('0),
        .rd_data (mem_rd),
        .all_q   (all_q)
    );

    always_comb begin
        // access blocked while protect shadow is zero
        acc_d     = all_q[OBSL_MAIN_PROT_BIT];
        rdata_d   = cpu_hit ? (mem_rd & OBSL_OPT1_RMASK) : 8'h00;
        cpu_sel_d = all_q[7:0];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q   <= OBSL_IDLE;
            cnt_q     <= 3'h0;
            idx_q     <= '0;
            rd_q      <= 1'b0;
            done_q    <= 1'b0;
            qual_q    <= 1'b0;
            acc_q     <= 1'b0;
            rdata_q   <= 8'h00;
            cpu_sel_q <= OBSL_OPT1_RST;
        end else begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            idx_q     <= idx_d;
            rd_q      <= rd_d;
            done_q    <= done_d;
            qual_q    <= qual_d;
            acc_q     <= acc_d;
            rdata_q   <= rdata_d;
            cpu_sel_q <= cpu_sel_d;
        end
    end

    // feature enables come from shadows, registered
    logic [8*NUM_BYTES-1:0] shadow_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shadow_q <= '0;
        end else begin
            shadow_q <= all_q;
        end
    end

    assign info_rd               = rd_q;
    assign info_idx              = idx_q;
    assign load_done             = done_q;
    assign cpu_rdata             = rdata_q;
    assign option_shadow         = shadow_q;
    assign main_memory_access_ok = acc_q;
    assign clock_no_divide       = cpu_sel_q[OBSL_NODIV_BIT];
    assign lower_half_protect    = cpu_sel_q[OBSL_LOW_PROT_BIT];

    // assertions
    a_access_follows_prot: assert property (@(posedge clk) disable iff (!resetn)
        main_memory_access_ok == $past(all_q[OBSL_MAIN_PROT_BIT]))
        else $error("access grant does not track protect shadow");
    a_block_when_zero: assert property (@(posedge clk) disable iff (!resetn)
        !$past(all_q[OBSL_MAIN_PROT_BIT]) |-> !main_memory_access_ok)
        else $error("access granted while protected");
    a_erase_sets_prot: assert property (@(posedge clk) disable iff (!resetn)
        mass_erase_done && !rd_q |=> all_q[OBSL_MAIN_PROT_BIT] ##1 main_memory_access_ok)
        else $error("mass erase did not set protect shadow");
    a_erase_grants: assert property (@(posedge clk) disable iff (!resetn)
        mass_erase_done && !rd_q |-> ##2 main_memory_access_ok)
        else $error("no access after mass erase");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
        cpu_rdata[7:3] == 5'h00)
        else $error("reserved bits read nonzero");
    a_recovery_no_load: assert property (@(posedge clk) disable iff (!resetn)
        state_q == OBSL_IDLE && !qual_q && !por_active && recovery_active
        && !stop_recovery_control[OBSL_RECOVER_LD_BIT] |=> state_q == OBSL_IDLE)
        else $error("load started on unqualified recovery reset");
    a_load_after_release: assert property (@(posedge clk) disable iff (!resetn)
        info_rd |-> !$past(in_reset))
        else $error("info read during reset");
    a_hold_no_write: assert property (@(posedge clk) disable iff (!resetn)
        !mem_wr |=> $stable(all_q))
        else $error("shadow changed without write");
    a_ro_bits_kept: assert property (@(posedge clk) disable iff (!resetn)
        cpu_wr && cpu_hit && !rd_q && !mass_erase_done |=>
        all_q[1:0] == $past(all_q[1:0]))
        else $error("cpu changed read-only bits");
    c_por_load: cover property (@(posedge clk) disable iff (!resetn) $rose(load_done));
    c_mass_erase: cover property (@(posedge clk) disable iff (!resetn)
        mass_erase_done && !all_q[0]);
    c_cpu_write: cover property (@(posedge clk) disable iff (!resetn) cpu_wr && cpu_hit);
endmodule // obsl_loader

// ==== dv/obsl_info_model.sv ====
// information block model: programmed option bytes behind a read port
module obsl_info_model #(
    parameter int NUM_BYTES = 2
) (
    // clock
    input  wire logic                         clk,
    // read port
    input  wire logic                         info_rd,
    input  wire logic [$clog2(NUM_BYTES)-1:0] info_idx,
    output logic      [7:0]                   info_data,
    // contents as last programmed
    input  wire logic [8*NUM_BYTES-1:0]       stored
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_q = 8'h00;
    // data only while strobed
    // idle bus toggles so a late sample cannot pass by luck
    always_comb begin
        info_data = info_rd ? stored[8*info_idx+:8] : ~last_q;
    end
    always_ff @(posedge clk) begin
        last_q <= info_data;
    end
endmodule // obsl_info_model

// ==== dv/tb_top.sv ====
// self-checking bench for the option bit shadow loader
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import obsl_pkg::*;
    logic        clk = 1'b0, resetn = 1'b0, por_active = 1'b1, recovery_active = 1'b0;
    logic [7:0]  stop_recovery_control = 8'h00, info_data, cpu_wdata = 8'h00, cpu_rdata;
    logic        info_rd, mass_erase_done = 1'b0, cpu_wr = 1'b0, load_done;
    logic [0:0]  info_idx;
    logic [11:0] cpu_addr = 12'h000;
    logic [15:0] option_shadow, stored = 16'h5a02;
    logic        main_memory_access_ok, clock_no_divide, lower_half_protect;
    int          errors = 0, checks_done = 0, cycles = 0, rd_cnt = 0;

    obsl_loader i_dut (.clk(clk), .resetn(resetn), .por_active(por_active),
        .recovery_active(recovery_active), .stop_recovery_control(stop_recovery_control),
        .info_rd(info_rd), .info_idx(info_idx), .info_data(info_data),
        .mass_erase_done(mass_erase_done), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .option_shadow(option_shadow),
        .main_memory_access_ok(main_memory_access_ok), .clock_no_divide(clock_no_divide),
        .lower_half_protect(lower_half_protect), .load_done(load_done));
    obsl_info_model i_info (.clk(clk), .info_rd(info_rd), .info_idx(info_idx),
        .info_data(info_data), .stored(stored));

    always #10 clk = ~clk;
    // cycle ceiling well above the roughly 80 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (info_rd === 1'b1) rd_cnt++;
        if (cycles == 3000) begin
            errors++;
            results();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_load();
        int i;
        int n0;
        n0 = rd_cnt;
        for (i = 0; i < 20 && rd_cnt < n0 + 2; i++) step(1);
        step(6);
        cmp(16'(rd_cnt - n0), 16'h0002);
        cmp({15'h0, load_done}, 16'h0001);
    endtask
    task automatic cpu_read(input logic [11:0] a, input logic [7:0] exp);
        cpu_addr = a;
        step(3);
        cmp({8'h0, cpu_rdata}, {8'h0, exp});
    endtask

    task automatic t_por();
        step(3);
        resetn = 1'b1;
        step(1);
        cmp({15'h0, clock_no_divide}, 16'h0001);
        cmp({14'h0, main_memory_access_ok, load_done}, 16'h0000);
        por_active = 1'b0;
        wait_load();
        cmp(option_shadow, 16'h5a02);
        cmp({13'h0, clock_no_divide, lower_half_protect, main_memory_access_ok},
            16'h0002);
        $display("test por load done");
    endtask
    task automatic t_cpu();
        cpu_read(OBSL_OPT1_ADDR, 8'h02);
        cpu_read(12'hd0e, 8'h00);
        cpu_addr = OBSL_OPT1_ADDR;
        cpu_wdata = 8'hff;
        cpu_wr = 1'b1;
        step(1);
        cpu_wr = 1'b0;
        step(2);
        cmp(option_shadow, 16'h5a06);
        cmp({15'h0, clock_no_divide}, 16'h0001);
        cpu_read(OBSL_OPT1_ADDR, 8'h06);
        $display("test cpu view done");
    endtask
    task automatic t_erase();
        mass_erase_done = 1'b1;
        step(1);
        mass_erase_done = 1'b0;
        step(2);
        cmp({15'h0, main_memory_access_ok}, 16'h0001);
        cmp(option_shadow, 16'h5a07);
        $display("test mass erase done");
    endtask
    task automatic t_recover();
        int n0;
        stored = 16'h3c05;
        step(4);
        cmp(option_shadow, 16'h5a07);
        // everything but the qualifying bit set
        stop_recovery_control = 8'hdf;
        n0 = rd_cnt;
        recovery_active = 1'b1;
        step(3);
        recovery_active = 1'b0;
        step(12);
        cmp(16'(rd_cnt - n0), 16'h0000);
        cmp(option_shadow, 16'h5a07);
        stop_recovery_control = 8'h20;
        recovery_active = 1'b1;
        step(3);
        recovery_active = 1'b0;
        wait_load();
        cmp(option_shadow, 16'h3c05);
        cmp({14'h0, main_memory_access_ok, clock_no_divide}, 16'h0003);
        $display("test recovery load done");
    endtask

    task automatic t_reset();
        resetn = 1'b0;
        por_active = 1'b1;
        step(2);
        cmp({15'h0, clock_no_divide}, 16'h0001);
        resetn = 1'b1;
        step(1);
        cmp({15'h0, clock_no_divide}, 16'h0001);
        cmp(option_shadow, 16'h0004);
        // write before the load completes must be refused
        cpu_addr = OBSL_OPT1_ADDR;
        cpu_wdata = 8'h00;
        cpu_wr = 1'b1;
        step(1);
        cpu_wr = 1'b0;
        step(2);
        cmp(option_shadow, 16'h0004);
        por_active = 1'b0;
        wait_load();
        cmp(option_shadow, 16'h3c05);
        cmp({14'h0, main_memory_access_ok, clock_no_divide}, 16'h0003);
        $display("test reset reload done");
    endtask

    task automatic results();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        t_por();
        t_cpu();
        t_erase();
        t_recover();
        t_reset();
        results();
    end
endmodule // tb_top
